// ### rtl/wdt_pkg.sv
`default_nettype none

package wdt_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_CLOCK_SELECT = 16'hff42;
  localparam logic [15:0] ADDR_MODE         = 16'hfff9;
  localparam logic [15:0] ADDR_IRQ_STATUS   = 16'hff48;
  localparam logic [15:0] ADDR_IRQ_MASK     = 16'hff4c;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          CLKSEL_LSB        = 0;
  localparam int          CLKSEL_W          = 3;
  localparam int          MODE_RUN_BIT      = 7;
  localparam int          MODE_SEL_BIT      = 4;
  localparam int          MODE_ACT_BIT      = 3;
  localparam logic [7:0]  CLKSEL_RESET      = 8'h00;
  localparam logic [7:0]  MODE_RESET        = 8'h00;
  localparam int          IRQ_INTERVAL_BIT  = 0;
  localparam int          IRQ_NMI_BIT       = 1;
  localparam int          IRQ_W             = 2;
  localparam logic [1:0]  IRQ_MASK_RESET    = 2'h0;

  // ---------------------------------------------------------------
  // Timing: prescaler exponents and overflow count
  // ---------------------------------------------------------------
  localparam int          PRESCALE_W        = 10;
  localparam logic [2:0]  CLKSEL_DIV16      = 3'h0;
  localparam logic [2:0]  CLKSEL_DIV64      = 3'h2;
  localparam logic [2:0]  CLKSEL_DIV256     = 3'h4;
  localparam logic [2:0]  CLKSEL_DIV1024    = 3'h6;
  localparam int          DIV16_EXP         = 4;
  localparam int          DIV64_EXP         = 6;
  localparam int          DIV256_EXP        = 8;
  localparam int          DIV1024_EXP       = 10;
  localparam int          OVERFLOW_COUNT    = 128;
  localparam int          COUNTER_W         = 7;

  typedef enum logic [1:0] {
    MODE_STOP     = 2'b00,
    MODE_INTERVAL = 2'b01,
    MODE_NMI      = 2'b10,
    MODE_RESET_GO = 2'b11
  } op_mode_e;

  typedef struct packed {
    logic       nmi;
    logic       reset_req;
    logic       interval;
  } wdt_event_s;

endpackage

`default_nettype wire

// ### rtl/wdt_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module wdt_prescaler #(
  parameter int W = wdt_pkg::PRESCALE_W
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       clear_i,
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  output logic            tick_o
);

  // Refuse a divider too short for the slowest count clock
  if (W < wdt_pkg::DIV1024_EXP) begin : g_width_check
    $error("Prescaler narrower than the slowest divide ratio");
  end

  logic [W-1:0] div_r;

  // Free divider restarted by a refresh, frozen in stop state
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      div_r <= '0;
    end else if (run_i) begin
      div_r <= div_r + 1'b1;
    end
  end

  // Tick on the last count of the selected /16,/64,/256,/1024 period
  always_comb begin
    case (sel_i)
      wdt_pkg::CLKSEL_DIV16:
        tick_o = run_i && (&div_r[wdt_pkg::DIV16_EXP-1:0]);
      wdt_pkg::CLKSEL_DIV64:
        tick_o = run_i && (&div_r[wdt_pkg::DIV64_EXP-1:0]);
      wdt_pkg::CLKSEL_DIV256:
        tick_o = run_i && (&div_r[wdt_pkg::DIV256_EXP-1:0]);
      wdt_pkg::CLKSEL_DIV1024:
        tick_o = run_i && (&div_r[wdt_pkg::DIV1024_EXP-1:0]);
      default:
        tick_o = 1'b0;
    endcase
  end

endmodule // wdt_prescaler

`default_nettype wire

// ### rtl/watchdog_interval_timer.sv
// Behaviour
// - Watchdog mode: missed refresh triggers non-maskable interrupt or reset.
// - Interval mode: periodic interrupt, no refresh needed.
// - Watchdog time is 2^11, 2^13, 2^15 or 2^17 clocks.
// - Interval period uses the same four values.
// - Clock select codes 000,010,100,110 give /16,/64,/256,/1024.
// - Reset clears the clock select register to zero.
// - Writing run bit clears counter and starts; only reset clears the run bit.
// - Mode bits 4:3: stop, interval, non-maskable interrupt, reset.
// - Mode bits 4 and 3 stay set until reset once written.
// - Counter runs in halt state, stops in stop state.
`timescale 1ns/10ps
`default_nettype none

module watchdog_interval_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // CPU power state
  input  wire logic        cpu_stop_i,
  // Events
  output logic             nmi_o,
  output logic             reset_req_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Overflow is the all-ones count, so the width must give it exactly
  localparam int COUNT_SPAN = 2 ** wdt_pkg::COUNTER_W;
  if (COUNT_SPAN != wdt_pkg::OVERFLOW_COUNT) begin : g_count_check
    $error("Counter width does not give the overflow count");
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [wdt_pkg::CLKSEL_W-1:0]  clock_select_r;
  logic                          run_r;
  logic                          watchdog_select_bit_r;
  logic                          overflow_action_bit_r;
  logic [wdt_pkg::IRQ_W-1:0]     irq_status_r;
  logic [wdt_pkg::IRQ_W-1:0]     irq_mask_r;
  logic [wdt_pkg::COUNTER_W-1:0] count_r;
  logic                          tick;
  logic                          overflow;
  logic                          refresh;
  wdt_pkg::op_mode_e             mode;
  wdt_pkg::wdt_event_s           evt;

  function automatic logic hit(input logic [15:0] a);
    hit = (adr_i == a);
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic req;
  logic wr;
  logic mapped;

  assign req    = cyc_i && stb_i && !ack_o && !err_o;
  assign mapped = hit(wdt_pkg::ADDR_CLOCK_SELECT) || hit(wdt_pkg::ADDR_MODE)
               || hit(wdt_pkg::ADDR_IRQ_STATUS) || hit(wdt_pkg::ADDR_IRQ_MASK);
  // Only lane 0 carries data; software must write the byte whole
  assign wr     = req && we_i && mapped && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req && !we_i) begin
      dat_o <= 32'h0000_0000;
      if (hit(wdt_pkg::ADDR_CLOCK_SELECT))
        dat_o[wdt_pkg::CLKSEL_W-1:0] <= clock_select_r;
      else if (hit(wdt_pkg::ADDR_MODE)) begin
        dat_o[wdt_pkg::MODE_RUN_BIT] <= run_r;
        dat_o[wdt_pkg::MODE_SEL_BIT] <= watchdog_select_bit_r;
        dat_o[wdt_pkg::MODE_ACT_BIT] <= overflow_action_bit_r;
      end else if (hit(wdt_pkg::ADDR_IRQ_STATUS))
        dat_o[wdt_pkg::IRQ_W-1:0] <= irq_status_r;
      else if (hit(wdt_pkg::ADDR_IRQ_MASK))
        dat_o[wdt_pkg::IRQ_W-1:0] <= irq_mask_r;
    end
  end

  // ---------------------------------------------------------------
  // Clock select
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_select_r <= wdt_pkg::CLKSEL_RESET[wdt_pkg::CLKSEL_W-1:0];
    end else if (wr && hit(wdt_pkg::ADDR_CLOCK_SELECT)) begin
      clock_select_r <= dat_i[wdt_pkg::CLKSEL_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Mode register: all bits sticky until reset
  // ---------------------------------------------------------------
  assign refresh = wr && hit(wdt_pkg::ADDR_MODE) && dat_i[wdt_pkg::MODE_RUN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r                 <= wdt_pkg::MODE_RESET[wdt_pkg::MODE_RUN_BIT];
      watchdog_select_bit_r <= wdt_pkg::MODE_RESET[wdt_pkg::MODE_SEL_BIT];
      overflow_action_bit_r <= wdt_pkg::MODE_RESET[wdt_pkg::MODE_ACT_BIT];
    end else if (wr && hit(wdt_pkg::ADDR_MODE)) begin
      run_r                 <= run_r | dat_i[wdt_pkg::MODE_RUN_BIT];
      watchdog_select_bit_r <= watchdog_select_bit_r
                             | dat_i[wdt_pkg::MODE_SEL_BIT];
      overflow_action_bit_r <= overflow_action_bit_r
                             | dat_i[wdt_pkg::MODE_ACT_BIT];
    end
  end

  assign mode = wdt_pkg::op_mode_e'({watchdog_select_bit_r,
                                     overflow_action_bit_r});

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  wdt_prescaler #(
    .W (wdt_pkg::PRESCALE_W)
  ) u_prescaler (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (refresh),
    .run_i   (run_r && !cpu_stop_i),
    .sel_i   (clock_select_r),
    .tick_o  (tick)
  );

  // 128 ticks of /16../1024 give 2^11..2^17 clocks
  assign overflow = tick && (&count_r);

  always_ff @(posedge clk_i) begin
    if (rst_i || refresh) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= count_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Overflow events
  // ---------------------------------------------------------------
  always_comb begin
    evt = '0;
    case (mode)
      wdt_pkg::MODE_INTERVAL: evt.interval  = overflow;
      wdt_pkg::MODE_NMI:      evt.nmi       = overflow;
      wdt_pkg::MODE_RESET_GO: evt.reset_req = overflow;
      default:                evt = '0;
    endcase
  end

  // Reset request is a pulse; system reset follows and clears us
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_o       <= 1'b0;
      reset_req_o <= 1'b0;
    end else begin
      nmi_o       <= evt.nmi;
      reset_req_o <= evt.reset_req;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask; set wins over write-one-clear
  // ---------------------------------------------------------------
  logic [wdt_pkg::IRQ_W-1:0] irq_set;
  logic [wdt_pkg::IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set                            = '0;
    irq_set[wdt_pkg::IRQ_NMI_BIT]      = evt.nmi;
    irq_set[wdt_pkg::IRQ_INTERVAL_BIT] = evt.interval;
  end

  assign irq_clr = (wr && hit(wdt_pkg::ADDR_IRQ_STATUS))
                 ? dat_i[wdt_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_r <= wdt_pkg::IRQ_MASK_RESET;
    end else if (wr && hit(wdt_pkg::ADDR_IRQ_MASK)) begin
      irq_mask_r <= dat_i[wdt_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

endmodule // watchdog_interval_timer

`default_nettype wire

// ### bench/wdt_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module wdt_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        nmi_o,
  input wire logic        reset_req_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = cyc_i && stb_i && !ack_o && !err_o;
  ack_resp_a: assert property (req |=> ack_o || err_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property ((ack_o || err_o) |=> !ack_o && !err_o)
    else $error("answer longer than one cycle");
  err_map_a: assert property (err_o |-> !($past(adr_i) inside
    {16'hff42, 16'hfff9, 16'hff48, 16'hff4c}))
    else $error("mapped address refused");
  clk_read_a: assert property (ack_o && !$past(we_i)
    && $past(adr_i) == 16'hff42 |-> dat_o[7:3] == 5'h00)
    else $error("clock select high bits not zero");
  event_excl_a: assert property (!(nmi_o && reset_req_o))
    else $error("both overflow actions at once");
  nmi_gap_a: assert property (nmi_o |=> !nmi_o [*8])
    else $error("overflow events too close");
  rst_gap_a: assert property (reset_req_o |=> !reset_req_o [*8])
    else $error("reset requests too close");
  irq_hold_a: assert property (irq_o && !req |=> irq_o)
    else $error("interrupt dropped without a write");
  quiet_rst_a: assert property (disable iff (1'b0) rst_i |=> !ack_o
    && !nmi_o && !reset_req_o && !irq_o)
    else $error("outputs active after reset");
  cover property (nmi_o);
  cover property (reset_req_o);
  cover property ($rose(irq_o));
endmodule // wdt_asserts
`default_nettype wire

// ### bench/tb_watchdog_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_watchdog_interval_timer;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stop = 0;
  logic [15:0] adr = 16'h0000;
  logic [3:0]  sel = 4'h1;
  logic [31:0] dat = 32'h0, dat_o;
  logic        ack_o, err_o, nmi_o, reset_req_o, irq_o, berr;
  logic [7:0]  q;
  int          err_count = 0, n_tests = 0, n;
  wire logic [2:0] ev = {irq_o, reset_req_o, nmi_o};
  watchdog_interval_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .cpu_stop_i(stop),
    .nmi_o(nmi_o), .reset_req_o(reset_req_o), .irq_o(irq_o));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    // No limit here: only the watchdog process ends a hung wait
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o[7:0];
    berr = err_o;
    cyc <= 0; stb <= 0;
  endtask
  task wt(input int k, input int lim);
    n = 0;
    while (ev[k] !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task do_reset();
    rst_i <= 1;
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
  endtask
  task finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
  initial begin
    do_reset();
    wb(0, 16'hff42, 0); chk(q, 8'h00);
    wb(0, 16'hfff9, 0); chk(q, 8'h00);
    wb(0, 16'h1234, 0); chk(berr, 1);
    foreach (q[i]) if (i < 4) begin
      wb(1, 16'hff42, 8'hf8 | 8'(2 * i));
      wb(0, 16'hff42, 0); chk(q, 8'(2 * i));
    end
    wb(1, 16'hff42, 8'h00);
    sel <= 4'h0;
    wb(1, 16'hff42, 8'h04);
    sel <= 4'h1;
    wb(0, 16'hff42, 0); chk(q, 8'h00);
    wb(1, 16'hff4c, 8'h03); wb(0, 16'hff4c, 0); chk(q, 8'h03);
    wb(1, 16'hfff9, 8'h80);
    wt(2, 2100); chk(n, 2100);
    wb(0, 16'hff48, 0); chk(q, 8'h00);
    $display("register test done");
    wb(1, 16'hfff9, 8'h88);
    wt(2, 2200); chk(n >= 2040 && n <= 2056, 1);
    wb(0, 16'hff48, 0); chk(q, 8'h01);
    wb(1, 16'hff48, 8'h01); chk(irq_o, 0);
    wb(1, 16'hff4c, 8'h00);
    wt(2, 2100); chk(n, 2100);
    wb(0, 16'hff48, 0); chk(q, 8'h01);
    wb(1, 16'hff4c, 8'h01); chk(irq_o, 1);
    wb(1, 16'hfff9, 8'h00); wb(0, 16'hfff9, 0); chk(q, 8'h88);
    $display("interval test done");
    wb(1, 16'hfff9, 8'h90); wb(0, 16'hfff9, 0); chk(q, 8'h98);
    repeat (3) begin
      wt(1, 1500); chk(n, 1500);
      wb(1, 16'hfff9, 8'h80);
    end
    wt(1, 2200); chk(n >= 2040 && n <= 2056, 1);
    $display("reset action test done");
    do_reset();
    wb(0, 16'hfff9, 0); chk(q, 8'h00);
    wb(1, 16'hfff9, 8'h90);
    stop <= 1;
    wt(0, 3000); chk(n, 3000);
    stop <= 0;
    wt(0, 2100); chk(n < 2100, 1);
    wb(0, 16'hff48, 0); chk(q, 8'h02);
    wb(1, 16'hff42, 8'h02); wb(1, 16'hfff9, 8'h80);
    wt(0, 8400); chk(n >= 8184 && n <= 8200, 1);
    $display("nmi test done");
    finish_test();
  end
endmodule // tb_watchdog_interval_timer
bind watchdog_interval_timer wdt_asserts chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .nmi_o(nmi_o),
  .reset_req_o(reset_req_o), .irq_o(irq_o));
`default_nettype wire
